// >>> src/srxup_device.sv
`timescale 1ns/1ns
`default_nettype none
module srxup_device #(
    parameter int DEPTH = srxup_pkg::SRXUP_DEPTH
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    srxup_if.device link,
    // receive side, fed by the line logic of this instance
    input wire logic rx_data_clock,
    input wire logic rx_data_clock_delayed,
    input wire logic rx_push,
    input wire logic [srxup_pkg::SRXUP_DATA_W-1:0] rx_push_word,
    input wire logic [srxup_pkg::SRXUP_BE_W-1:0] rx_push_bytes,
    input wire logic [srxup_pkg::SRXUP_PORT_W-1:0] rx_push_port,
    input wire logic rx_push_first,
    input wire logic rx_push_last,
    input wire logic rx_push_fault,
    input wire logic [srxup_pkg::SRXUP_PORT_W-1:0] status_read_index,
    input wire logic [srxup_pkg::SRXUP_STAT_W-1:0] internal_flow_state,
    output logic [srxup_pkg::SRXUP_STAT_W-1:0] status_out,
    output logic capture_clock,
    output logic [srxup_pkg::SRXUP_TAP_W-1:0] capture_tap
);
    import srxup_pkg::*;
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [SRXUP_DATA_W-1:0] word;
        logic [SRXUP_BE_W-1:0] bytes;
        logic [SRXUP_PORT_W-1:0] port;
        logic first;
        logic last;
        logic fault;
    } srxup_entry_t;

    // ==========================================
    // status memory, on the user write clock
    logic [SRXUP_STAT_W-1:0] flow_ram [SRXUP_PORTS];
    always_ff @(posedge link.flow_state_ram_write_clock) begin
        if (link.flow_state_ram_write_enable) begin
            flow_ram[link.status_ram_write_index] <=
                link.port_flow_state_in;
        end
    end
    // ext select: stored user status replaces the internal one
    always_comb begin
        status_out = link.external_flow_state_select ?
            flow_ram[status_read_index] : internal_flow_state;
    end

    // ==========================================
    // capture clock path
    always_comb begin
        capture_clock = link.rx_clock_delay_line_enable ?
            rx_data_clock_delayed : rx_data_clock;
        // taps above six are out of range; clamp to the last valid tap
        capture_tap = (link.rx_clock_delay_tap_select > SRXUP_TAP_MAX) ?
            SRXUP_TAP_MAX : link.rx_clock_delay_tap_select;
    end

    // ==========================================
    // quarter-rate status clock
    logic [1:0] qdiv;
    logic [1:0] next_qdiv;
    logic qclk;
    logic next_qclk;
    always_comb begin
        next_qdiv = qdiv + 2'h1;
        next_qclk = qclk;
        if (qdiv[0]) begin
            next_qclk = ~qclk;
        end
    end
    always_ff @(posedge rx_data_clock or negedge rstn) begin
        if (!rstn) begin
            qdiv <= 2'h0;
            qclk <= 1'b0;
        end else begin
            qdiv <= next_qdiv;
            qclk <= next_qclk;
        end
    end
    assign link.rx_status_quarter_clock = qclk;

    // ==========================================
    // receive queue, read by word select
    srxup_entry_t mem [DEPTH];
    logic [AW:0] wptr;
    logic [AW:0] next_wptr;
    logic [AW:0] rptr;
    logic [AW:0] next_rptr;
    srxup_entry_t rdq;
    srxup_entry_t next_rdq;
    logic [AW:0] level;
    logic push_ok;
    logic pop_ok;
    always_comb begin
        level = wptr - rptr;
        push_ok = rx_push && (level != (AW+1)'(DEPTH));
        pop_ok = link.wide_read_enable && (level != '0);
        next_wptr = push_ok ? wptr + (AW+1)'(1) : wptr;
        next_rptr = pop_ok ? rptr + (AW+1)'(1) : rptr;
        next_rdq = rdq;
        if (link.wide_read_enable) begin
            // word select is an offset from the read head
            next_rdq = mem[AW'(rptr[AW-1:0] +
                AW'(link.wide_read_word_select))];
        end
    end
    always_ff @(posedge clk) begin
        if (ce && push_ok) begin
            mem[wptr[AW-1:0]] <= '{word: rx_push_word, bytes: rx_push_bytes,
                port: rx_push_port, first: rx_push_first,
                last: rx_push_last, fault: rx_push_fault};
        end
    end
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wptr <= '0;
            rptr <= '0;
            rdq <= '0;
        end else if (ce) begin
            wptr <= next_wptr;
            rptr <= next_rptr;
            rdq <= next_rdq;
        end
    end
    always_comb begin
        link.wide_read_word = rdq.word;
        link.wide_read_byte_valid = rdq.bytes;
        link.wide_read_logical_port = rdq.port;
        link.wide_read_packet_first = rdq.first;
        link.wide_read_packet_last = rdq.last;
        link.wide_read_word_fault = rdq.fault;
        if (link.drained_flag_type_select) begin
            link.wide_read_queue_drained =
                (level <= (AW+1)'(DEPTH/4 - 1));
        end else begin
            link.wide_read_queue_drained = (level == '0);
        end
    end
    // each instance is one copy of this module
endmodule
`default_nettype wire

// >>> src/srxup_if.sv
`timescale 1ns/1ns
`default_nettype none
interface srxup_if;
    import srxup_pkg::*;
    logic [SRXUP_PORT_W-1:0] status_ram_write_index;
    logic [SRXUP_STAT_W-1:0] port_flow_state_in;
    logic external_flow_state_select;
    logic flow_state_ram_write_enable;
    logic flow_state_ram_write_clock;
    logic rx_clock_delay_line_enable;
    logic [SRXUP_TAP_W-1:0] rx_clock_delay_tap_select;
    logic rx_status_quarter_clock;
    logic [SRXUP_ADDR_W-1:0] wide_read_word_select;
    logic wide_read_enable;
    logic [SRXUP_DATA_W-1:0] wide_read_word;
    logic [SRXUP_BE_W-1:0] wide_read_byte_valid;
    logic [SRXUP_PORT_W-1:0] wide_read_logical_port;
    logic wide_read_packet_first;
    logic wide_read_packet_last;
    logic wide_read_word_fault;
    logic wide_read_queue_drained;
    logic drained_flag_type_select;
    modport device (
        input status_ram_write_index, port_flow_state_in,
        input external_flow_state_select, flow_state_ram_write_enable,
        input flow_state_ram_write_clock, rx_clock_delay_line_enable,
        input rx_clock_delay_tap_select, wide_read_word_select,
        input wide_read_enable, drained_flag_type_select,
        output rx_status_quarter_clock, wide_read_word,
        output wide_read_byte_valid, wide_read_logical_port,
        output wide_read_packet_first, wide_read_packet_last,
        output wide_read_word_fault, wide_read_queue_drained
    );
    modport user (
        output status_ram_write_index, port_flow_state_in,
        output external_flow_state_select, flow_state_ram_write_enable,
        output flow_state_ram_write_clock, rx_clock_delay_line_enable,
        output rx_clock_delay_tap_select, wide_read_word_select,
        output wide_read_enable, drained_flag_type_select,
        input rx_status_quarter_clock, wide_read_word,
        input wide_read_byte_valid, wide_read_logical_port,
        input wide_read_packet_first, wide_read_packet_last,
        input wide_read_word_fault, wide_read_queue_drained
    );
endinterface
`default_nettype wire

// >>> src/srxup_pkg.sv
package srxup_pkg;
    // ==========================================
    // widths
    localparam int SRXUP_PORT_W = 8;
    localparam int SRXUP_STAT_W = 2;
    localparam int SRXUP_TAP_W = 3;
    localparam int SRXUP_ADDR_W = 3;
    localparam int SRXUP_DATA_W = 128;
    localparam int SRXUP_BE_W = 16;
    localparam int SRXUP_PORTS = 256;
    localparam int SRXUP_DEPTH = 8;
    // ==========================================
    // values and counts
    localparam logic [2:0] SRXUP_TAP_MAX = 3'h6;
    localparam logic [1:0] SRXUP_QDIV_LAST = 2'h3;
    localparam logic [1:0] SRXUP_STAT_RESET = 2'h0;
    localparam logic [3:0] SRXUP_LEVEL_RESET = 4'h0;
    // drained threshold for type one: quarter full minus one
    localparam logic [3:0] SRXUP_QUARTER_M1 = 4'h1;
    // ==========================================
    // user-side register offsets (byte address, word index = address / 4)
    localparam logic [7:0] SRXUP_REG_CTRL = 8'h00;
    localparam logic [7:0] SRXUP_REG_STAT = 8'h04;
    localparam logic [7:0] SRXUP_REG_IRQ_ST = 8'h08;
    localparam logic [7:0] SRXUP_REG_IRQ_CLR = 8'h0c;
    localparam logic [7:0] SRXUP_REG_IRQ_EN = 8'h10;
    localparam logic [7:0] SRXUP_REG_WORD = 8'h14;
    localparam logic [7:0] SRXUP_REG_FSTAT = 8'h18;
    localparam logic [7:0] SRXUP_REG_CMD = 8'h1c;
    // ctrl fields
    localparam int SRXUP_C_EXT = 0;
    localparam int SRXUP_C_DLY = 1;
    localparam int SRXUP_C_TAP = 2;
    localparam int SRXUP_C_TYPE = 5;
    // cmd fields
    localparam int SRXUP_K_WR = 0;
    localparam int SRXUP_K_RD = 1;
    localparam int SRXUP_K_ADDR = 4;
    localparam int SRXUP_K_PORT = 8;
    localparam int SRXUP_K_STAT = 16;
    // irq bits
    localparam int SRXUP_I_FIRST = 0;
    localparam int SRXUP_I_LAST = 1;
    localparam int SRXUP_I_FAULT = 2;
    localparam int SRXUP_I_W = 3;
endpackage

// >>> src/srxup_user.sv
`timescale 1ns/1ns
`default_nettype none
module srxup_user (
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    srxup_if.user link,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    output logic irq
);
    import srxup_pkg::*;
    logic [5:0] ctrl;
    logic [5:0] next_ctrl;
    logic [2:0] ien;
    logic [2:0] next_ien;
    logic [2:0] ist;
    logic [2:0] next_ist;
    logic [31:0] next_rdata;
    logic [127:0] word;
    logic [127:0] next_word;
    logic [31:0] fstat;
    logic [31:0] next_fstat;
    logic [18:0] cmd;
    logic [18:0] next_cmd;
    logic got;
    logic next_got;
    logic [2:0] ev;

    // ==========================================
    // register access and command issue
    always_comb begin
        next_ctrl = ctrl;
        next_ien = ien;
        next_cmd = cmd;
        next_cmd[SRXUP_K_WR] = 1'b0;
        next_cmd[SRXUP_K_RD] = 1'b0;
        next_got = cmd[SRXUP_K_RD];
        next_word = word;
        next_fstat = fstat;
        ev = '0;
        if (got) begin
            next_word = link.wide_read_word;
            next_fstat = {link.wide_read_byte_valid,
                link.wide_read_logical_port, 5'h0,
                link.wide_read_word_fault, link.wide_read_packet_last,
                link.wide_read_packet_first};
            ev = {link.wide_read_word_fault, link.wide_read_packet_last,
                link.wide_read_packet_first};
        end
        // set wins over clear
        next_ist = ist | ev;
        if (wr) begin
            unique case (addr)
                SRXUP_REG_CTRL: next_ctrl = wdata[5:0];
                SRXUP_REG_IRQ_EN: next_ien = wdata[2:0];
                SRXUP_REG_IRQ_CLR: next_ist = (ist & ~wdata[2:0]) | ev;
                SRXUP_REG_CMD: next_cmd = wdata[18:0];
                default: ;
            endcase
        end
        next_rdata = '0;
        if (rd) begin
            unique case (addr)
                SRXUP_REG_CTRL: next_rdata = {26'h0, ctrl};
                SRXUP_REG_STAT: next_rdata = {31'h0,
                    link.wide_read_queue_drained};
                SRXUP_REG_IRQ_ST: next_rdata = {29'h0, ist};
                SRXUP_REG_IRQ_EN: next_rdata = {29'h0, ien};
                SRXUP_REG_WORD: next_rdata = word[31:0];
                SRXUP_REG_FSTAT: next_rdata = fstat;
                default: next_rdata = '0;
            endcase
        end
    end
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ctrl <= '0;
            ien <= '0;
            ist <= '0;
            rdata <= '0;
            word <= '0;
            fstat <= '0;
            cmd <= '0;
            got <= 1'b0;
        end else if (ce) begin
            ctrl <= next_ctrl;
            ien <= next_ien;
            ist <= next_ist;
            rdata <= next_rdata;
            word <= next_word;
            fstat <= next_fstat;
            cmd <= next_cmd;
            got <= next_got;
        end
    end
    always_comb begin
        irq = |(ist & ien);
        link.external_flow_state_select = ctrl[SRXUP_C_EXT];
        // delay enable only meaningful for static capture
        link.rx_clock_delay_line_enable = ctrl[SRXUP_C_DLY];
        link.rx_clock_delay_tap_select = (ctrl[4:2] > SRXUP_TAP_MAX) ?
            SRXUP_TAP_MAX : ctrl[4:2];
        link.drained_flag_type_select = ctrl[SRXUP_C_TYPE];
        link.status_ram_write_index = cmd[15:8];
        link.port_flow_state_in = cmd[17:16];
        link.flow_state_ram_write_enable = cmd[SRXUP_K_WR];
        // write clock is inverted so data is stable at its edge
        link.flow_state_ram_write_clock = ~clk;
        link.wide_read_word_select = cmd[6:4];
        link.wide_read_enable = cmd[SRXUP_K_RD];
    end
endmodule
`default_nettype wire

// >>> testbench/srxup_checker.sv
`timescale 1ns/1ns
`default_nettype none
module srxup_checker (
    input wire logic clk,
    input wire logic rstn,
    input wire logic wide_read_enable,
    input wire logic [srxup_pkg::SRXUP_DATA_W-1:0] wide_read_word,
    input wire logic [srxup_pkg::SRXUP_BE_W-1:0] wide_read_byte_valid,
    input wire logic [srxup_pkg::SRXUP_PORT_W-1:0] wide_read_logical_port,
    input wire logic wide_read_packet_first,
    input wire logic wide_read_packet_last,
    input wire logic wide_read_word_fault,
    input wire logic flow_state_ram_write_enable,
    input wire logic [srxup_pkg::SRXUP_PORT_W-1:0] status_ram_write_index,
    input wire logic [srxup_pkg::SRXUP_STAT_W-1:0] port_flow_state_in,
    input wire logic [srxup_pkg::SRXUP_TAP_W-1:0] rx_clock_delay_tap_select
);
    import srxup_pkg::*;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);
    // ==========================================
    // read port: word, tags and flags move only after a read enable, even one that pops nothing
    chk_read_pulse:
        assert property (wide_read_enable |=> !wide_read_enable)
        else $error("read enable wider than one cycle");
    chk_word_hold:
        assert property (!wide_read_enable |=> $stable(wide_read_word))
        else $error("read word changed without a read");
    chk_tags_hold:
        assert property (!wide_read_enable |=>
            $stable({wide_read_byte_valid, wide_read_logical_port}))
        else $error("byte valid or port changed without a read");
    chk_first_cause:
        assert property ($rose(wide_read_packet_first) |->
            $past(wide_read_enable))
        else $error("first flag rose without a read");
    chk_last_cause:
        assert property ($rose(wide_read_packet_last) |->
            $past(wide_read_enable))
        else $error("last flag rose without a read");
    chk_fault_cause:
        assert property ($changed(wide_read_word_fault) |->
            $past(wide_read_enable))
        else $error("fault flag moved without a read");
    // ==========================================
    // status memory write side and delay tap range
    chk_write_pulse:
        assert property (flow_state_ram_write_enable |=>
            !flow_state_ram_write_enable)
        else $error("status write enable wider than one cycle");
    chk_write_hold:
        assert property (flow_state_ram_write_enable |=>
            $stable(status_ram_write_index) && $stable(port_flow_state_in))
        else $error("index or state moved during the write");
    chk_tap_range:
        assert property (rx_clock_delay_tap_select <= SRXUP_TAP_MAX)
        else $error("tap select above six");
endmodule
`default_nettype wire

// >>> testbench/tb_spi4_rx_user_side_port.sv
`timescale 1ns/1ns
`default_nettype none
module tb_spi4_rx_user_side_port;
    import srxup_pkg::*;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic ce = 1'b1;
    logic dclk = 1'b0;
    logic dclk_dly;
    logic push = 1'b0;
    logic [127:0] p_word = '0;
    logic [15:0] p_bytes = '0;
    logic [7:0] p_port = '0;
    logic [2:0] p_flag = '0;
    logic [7:0] st_idx = '0;
    logic [1:0] st_int = '0;
    logic [1:0] st_out;
    logic cap_clk;
    logic [2:0] cap_tap;
    logic [7:0] addr = '0;
    logic [31:0] wdata = '0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [31:0] rdata;
    logic irq;
    int mismatches = 0;
    int checks_done = 0;
    int qrise = 0;
    logic [127:0] wd [3];
    logic [15:0] be_t [3] = '{16'hffff, 16'hffff, 16'h00ff};
    logic [2:0] fl_t [3] = '{3'h1, 3'h0, 3'h6};
    srxup_if link_if();
    always #5 clk = ~clk;
    // data clock unrelated to clk
    always #7 dclk = ~dclk;
    assign #2 dclk_dly = dclk;
    always @(posedge link_if.rx_status_quarter_clock) qrise++;
    srxup_device u_srxup_device (.clk(clk), .rstn(rstn), .ce(ce),
        .link(link_if.device), .rx_data_clock(dclk),
        .rx_data_clock_delayed(dclk_dly), .rx_push(push),
        .rx_push_word(p_word), .rx_push_bytes(p_bytes),
        .rx_push_port(p_port), .rx_push_first(p_flag[0]),
        .rx_push_last(p_flag[1]), .rx_push_fault(p_flag[2]),
        .status_read_index(st_idx), .internal_flow_state(st_int),
        .status_out(st_out), .capture_clock(cap_clk),
        .capture_tap(cap_tap));
    srxup_user u_srxup_user (.clk(clk), .rstn(rstn), .ce(ce),
        .link(link_if.user), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .irq(irq));
    srxup_checker u_srxup_checker (.clk(clk), .rstn(rstn),
        .wide_read_enable(link_if.wide_read_enable),
        .wide_read_word(link_if.wide_read_word),
        .wide_read_byte_valid(link_if.wide_read_byte_valid),
        .wide_read_logical_port(link_if.wide_read_logical_port),
        .wide_read_packet_first(link_if.wide_read_packet_first),
        .wide_read_packet_last(link_if.wide_read_packet_last),
        .wide_read_word_fault(link_if.wide_read_word_fault),
        .flow_state_ram_write_enable(link_if.flow_state_ram_write_enable),
        .status_ram_write_index(link_if.status_ram_write_index),
        .port_flow_state_in(link_if.port_flow_state_in),
        .rx_clock_delay_tap_select(link_if.rx_clock_delay_tap_select));
    // ==========================================
    // shared tasks
    task automatic check(input logic [127:0] got, input logic [127:0] exp);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic stop_test();
        $display("mismatches %0d checks_done %0d", mismatches, checks_done);
        if (mismatches == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 check(rdata, e);
    endtask
    task automatic push_word(input int i);
        @(posedge clk);
        push <= 1'b1;
        p_word <= wd[i];
        p_bytes <= be_t[i];
        p_port <= 8'h30 + 8'(i);
        p_flag <= fl_t[i];
        @(posedge clk);
        push <= 1'b0;
    endtask
    // ==========================================
    // scenarios
    task automatic sc_reset();
        rd_reg(SRXUP_REG_STAT, 32'h1);
        rd_reg(SRXUP_REG_IRQ_ST, 32'h0);
        rd_reg(8'h40, 32'h0);
        check(irq, 1'b0);
    endtask
    task automatic sc_control();
        wr_reg(SRXUP_REG_CTRL, 32'h1b);
        repeat (2) @(posedge clk);
        check(link_if.rx_clock_delay_tap_select, 3'h6);
        check(cap_tap, 3'h6);
        check(link_if.external_flow_state_select, 1'b1);
        // 1 ns after a data edge only the bypass path has risen
        @(posedge dclk) #1 check(cap_clk, 1'b0);
        wr_reg(SRXUP_REG_CTRL, 32'h18);
        @(posedge dclk) #1 check(cap_clk, 1'b1);
        check(link_if.rx_clock_delay_line_enable, 1'b0);
        // tap field seven must never reach the delay line
        wr_reg(SRXUP_REG_CTRL, 32'h1c);
        repeat (2) @(posedge clk);
        check(link_if.rx_clock_delay_tap_select, 3'h6);
        check(cap_tap, 3'h6);
        rd_reg(SRXUP_REG_CTRL, 32'h1c);
    endtask
    task automatic sc_status_ram();
        wr_reg(SRXUP_REG_CTRL, 32'h19);
        wr_reg(SRXUP_REG_CMD, 32'h0002_5a01);
        st_idx <= 8'h5a;
        st_int <= 2'h1;
        wr_reg(SRXUP_REG_CMD, 32'h0003_5b01);
        repeat (3) @(posedge clk);
        check(st_out, 2'h2);
        check(link_if.status_ram_write_index, 8'h5b);
        check(link_if.port_flow_state_in, 2'h3);
        st_idx <= 8'h5b;
        repeat (2) @(posedge clk);
        check(st_out, 2'h3);
        wr_reg(SRXUP_REG_CTRL, 32'h18);
        repeat (2) @(posedge clk);
        check(st_out, 2'h1);
    endtask
    task automatic sc_read_path();
        logic [2:0] sel [3] = '{3'h0, 3'h1, 3'h0};
        // a read pops one word whatever its offset from the head
        int pick [3] = '{0, 2, 2};
        logic [2:0] ist [3] = '{3'h1, 3'h7, 3'h6};
        wr_reg(SRXUP_REG_CTRL, 32'h38);
        push_word(0);
        repeat (2) @(posedge clk);
        check(link_if.wide_read_queue_drained, 1'b1);
        wr_reg(SRXUP_REG_CTRL, 32'h18);
        repeat (2) @(posedge clk);
        check(link_if.wide_read_queue_drained, 1'b0);
        push_word(1);
        push_word(2);
        for (int k = 0; k < 3; k++) begin
            if (k == 1) wr_reg(SRXUP_REG_IRQ_EN, 32'h7);
            if (k == 2) wr_reg(SRXUP_REG_IRQ_CLR, 32'h7);
            wr_reg(SRXUP_REG_CMD, {25'h0, sel[k], 4'h2});
            repeat (3) @(posedge clk);
            check(link_if.wide_read_word, wd[pick[k]]);
            check(link_if.wide_read_byte_valid, be_t[pick[k]]);
            check(link_if.wide_read_logical_port,
                8'h30 + 8'(pick[k]));
            rd_reg(SRXUP_REG_FSTAT, {be_t[pick[k]], 8'h30 + 8'(pick[k]),
                5'h0, fl_t[pick[k]]});
            rd_reg(SRXUP_REG_WORD, wd[pick[k]][31:0]);
            rd_reg(SRXUP_REG_IRQ_ST, {29'h0, ist[k]});
            check(irq, k != 0);
        end
        check(link_if.wide_read_queue_drained, 1'b1);
    endtask
    task automatic sc_freeze();
        // a write while the enable is low must leave ctrl alone
        @(posedge clk);
        ce <= 1'b0;
        wr_reg(SRXUP_REG_CTRL, 32'h01);
        @(posedge clk);
        ce <= 1'b1;
        rd_reg(SRXUP_REG_CTRL, 32'h18);
        rd_reg(SRXUP_REG_STAT, 32'h1);
    endtask
    task automatic sc_quarter();
        int q0;
        @(posedge dclk);
        q0 = qrise;
        repeat (16) @(posedge dclk);
        check(qrise - q0, 4);
    endtask
    initial begin
        for (int i = 0; i < 3; i++) wd[i] = {4{32'h9a00_0000 + 32'(i)}};
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        sc_reset();
        sc_control();
        sc_status_ram();
        sc_read_path();
        sc_freeze();
        sc_quarter();
        stop_test();
    end
    // hang guard
    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        stop_test();
    end
endmodule
`default_nettype wire
